// *** pkg/hcb_defs.svh ***
/*
 * constants of the hysteresis compare block: widths, operand indices,
 * reset values of the operand configuration.
 * assumes nothing; definitions only, included by bare name.
 */
`ifndef HCB_DEFS_SVH
`define HCB_DEFS_SVH

// --------------------------------------------------------------
// widths
// --------------------------------------------------------------
`define HCB_DATA_W 16
`define HCB_CHAN_W 3
`define HCB_CHAN_COUNT 8
`define HCB_OPND_W 2

// --------------------------------------------------------------
// operand indices on the configuration port
// --------------------------------------------------------------
`define HCB_OPND_INPUT 2'h0
`define HCB_OPND_LOW 2'h1
`define HCB_OPND_HIGH 2'h2

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define HCB_CONST_RESET 16'h0000
`define HCB_CHAN_RESET 3'h0
`define HCB_VALUE_RESET 16'h0000

`endif

// *** pkg/hcb_pkg.sv ***
/*
 * types of the hysteresis compare block: operand source, output state,
 * zone of the input against the limits.
 * assumes hcb_defs.svh is not needed here; types only.
 */
`default_nettype none
package hcb_pkg;

	// operand source selection
	typedef enum logic [1:0]
	{
		hcb_src_constant = 2'b00,
		hcb_src_analog = 2'b01,
		hcb_src_block = 2'b10
	} hcb_source_type;

	// output state
	typedef enum logic
	{
		hcb_out_off = 1'b0,
		hcb_out_on = 1'b1
	} hcb_state_type;

	// where the input stood at the last enabled evaluation
	typedef enum logic [1:0]
	{
		hcb_zone_hold = 2'b00,
		hcb_zone_on = 2'b01,
		hcb_zone_off = 2'b10
	} hcb_zone_type;

endpackage
`default_nettype wire

// *** src/hcb_operand_select.sv ***
/*
 * one operand of the hysteresis compare block: holds its source
 * configuration and the last value captured from a channel or block.
 * assumes channel and block values come from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hcb_defs.svh"

module hcb_operand_select
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	// gating
	input wire logic enable,
	// configuration write for this operand
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_source,
	input wire logic [`HCB_DATA_W-1:0] cfg_constant,
	input wire logic [`HCB_CHAN_W-1:0] cfg_channel,
	// live sources
	input wire logic [`HCB_CHAN_COUNT-1:0][`HCB_DATA_W-1:0] analog_channel,
	input wire logic [`HCB_DATA_W-1:0] block_value,
	// results
	output logic [`HCB_DATA_W-1:0] operand_value,
	output logic [`HCB_DATA_W-1:0] captured_reg,
	output logic [1:0] source_reg,
	output logic [`HCB_CHAN_W-1:0] channel_reg,
	output logic [`HCB_DATA_W-1:0] constant_reg,
	output logic cfg_bad
);

	logic [`HCB_DATA_W-1:0] live_value;
	logic [`HCB_DATA_W-1:0] captured_next;

	// source configuration, constant zero and channel 0 after reset
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			source_reg <= hcb_pkg::hcb_src_constant;
			constant_reg <= `HCB_CONST_RESET;
			channel_reg <= `HCB_CHAN_RESET;
		end
		else if (ce && cfg_wr)
		begin
			source_reg <= cfg_source;
			constant_reg <= cfg_constant;
			channel_reg <= cfg_channel;
		end
	end

	// an unused source code would silently act as a block source
	assign cfg_bad = cfg_wr && (cfg_source != hcb_pkg::hcb_src_constant) &&
		(cfg_source != hcb_pkg::hcb_src_analog) && (cfg_source != hcb_pkg::hcb_src_block);

	// live value of a channel or block source
	always_comb
	begin
		unique case (source_reg)
			hcb_pkg::hcb_src_analog: live_value = analog_channel[channel_reg];
			hcb_pkg::hcb_src_block: live_value = block_value;
			default: live_value = block_value;
		endcase
	end

	// capture only while enabled, hold otherwise
	assign captured_next = enable ? live_value : captured_reg;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			captured_reg <= `HCB_VALUE_RESET;
		else if (ce && enable && (source_reg != hcb_pkg::hcb_src_constant))
			captured_reg <= captured_next;
	end

	// constant is used directly, others through the capture
	assign operand_value = (source_reg == hcb_pkg::hcb_src_constant) ? constant_reg : captured_next;

endmodule
`default_nettype wire

// *** src/hcb_hysteresis_compare.sv ***
/*
 * hysteresis compare block: compares a signed input operand with a low
 * and a high limit and drives one held binary output.
 * assumes enable, channel and block values come from logic on clk_sys,
 * and configuration writes come from the controller's own logic.
 */
// Operation
// - each operand picks constant, channel or block
// - constant is signed sixteen bit, resets zero
// - channel operand picks one of eight, first default
// - high above low: on at input >= high
// - high above low: off at input <= low
// - high above low: between limits, output holds
// - high below low: off at input >= low
// - operands captured only while enable high
// - evaluation and output change only when enabled
// - disabled output holds last state, even on
`timescale 1ns/1ps
`default_nettype none
`include "hcb_defs.svh"

module hcb_hysteresis_compare
(
	// clock, reset, clock enable
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	// block input pin
	input wire logic enable,
	// operand configuration port
	input wire logic cfg_wr,
	input wire logic [`HCB_OPND_W-1:0] cfg_operand,
	input wire logic [1:0] cfg_source,
	input wire logic [`HCB_DATA_W-1:0] cfg_constant,
	input wire logic [`HCB_CHAN_W-1:0] cfg_channel,
	// value sources
	input wire logic [`HCB_CHAN_COUNT-1:0][`HCB_DATA_W-1:0] analog_channel,
	input wire logic [`HCB_DATA_W-1:0] block_value_input,
	input wire logic [`HCB_DATA_W-1:0] block_value_low,
	input wire logic [`HCB_DATA_W-1:0] block_value_high,
	// block output
	output logic out_on,
	output logic switched_on,
	output logic switched_off,
	// status
	output logic [1:0] zone,
	output logic limits_reversed,
	output logic cfg_error,
	output logic [`HCB_DATA_W-1:0] input_operand_value
);

	// ----------------------------------------------------------
	// declarations
	// ----------------------------------------------------------
	logic wr_input;
	logic wr_low;
	logic wr_high;
	logic bad_input;
	logic bad_low;
	logic bad_high;
	logic bad_index;
	logic signed [`HCB_DATA_W-1:0] input_operand;
	logic signed [`HCB_DATA_W-1:0] low_limit;
	logic signed [`HCB_DATA_W-1:0] high_limit;
	logic [`HCB_DATA_W-1:0] input_raw;
	logic [`HCB_DATA_W-1:0] low_raw;
	logic [`HCB_DATA_W-1:0] high_raw;
	logic at_or_above_high;
	logic at_or_below_low;
	logic at_or_above_low;
	logic at_or_below_high;
	logic reversed;
	hcb_pkg::hcb_zone_type zone_now;
	hcb_pkg::hcb_state_type state_reg;
	hcb_pkg::hcb_state_type state_next;
	hcb_pkg::hcb_zone_type zone_reg;
	logic reversed_reg;
	logic cfg_error_reg;
	logic switched_on_reg;
	logic switched_off_reg;
	logic [`HCB_DATA_W-1:0] input_value_reg;

	// ----------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------

	// one write strobe for each operand
	assign wr_input = cfg_wr && (cfg_operand == `HCB_OPND_INPUT);
	assign wr_low = cfg_wr && (cfg_operand == `HCB_OPND_LOW);
	assign wr_high = cfg_wr && (cfg_operand == `HCB_OPND_HIGH);

	// a write to no operand is reported, not stored
	assign bad_index = cfg_wr && !wr_input && !wr_low && !wr_high;

	// ----------------------------------------------------------
	// operands
	// ----------------------------------------------------------

	// one shared configuration bus for all three operands;
	// only the addressed instance stores a write,
	// so a write never disturbs the other two;
	// constants bypass the capture and apply at once

	// input operand
	hcb_operand_select u_input
	(
		.clk_sys(clk_sys),
		.srst(srst),
		.ce(ce),
		.enable(enable),
		.cfg_wr(wr_input),
		.cfg_source(cfg_source),
		.cfg_constant(cfg_constant),
		.cfg_channel(cfg_channel),
		.analog_channel(analog_channel),
		.block_value(block_value_input),
		.operand_value(input_raw),
		.captured_reg(),
		.source_reg(),
		.channel_reg(),
		.constant_reg(),
		.cfg_bad(bad_input)
	);

	// low limit
	hcb_operand_select u_low
	(
		.clk_sys(clk_sys),
		.srst(srst),
		.ce(ce),
		.enable(enable),
		.cfg_wr(wr_low),
		.cfg_source(cfg_source),
		.cfg_constant(cfg_constant),
		.cfg_channel(cfg_channel),
		.analog_channel(analog_channel),
		.block_value(block_value_low),
		.operand_value(low_raw),
		.captured_reg(),
		.source_reg(),
		.channel_reg(),
		.constant_reg(),
		.cfg_bad(bad_low)
	);

	// high limit
	hcb_operand_select u_high
	(
		.clk_sys(clk_sys),
		.srst(srst),
		.ce(ce),
		.enable(enable),
		.cfg_wr(wr_high),
		.cfg_source(cfg_source),
		.cfg_constant(cfg_constant),
		.cfg_channel(cfg_channel),
		.analog_channel(analog_channel),
		.block_value(block_value_high),
		.operand_value(high_raw),
		.captured_reg(),
		.source_reg(),
		.channel_reg(),
		.constant_reg(),
		.cfg_bad(bad_high)
	);

	// raw buses carry two's complement values;
	// unsigned compares would misorder negative limits
	// signed views of the three operands
	assign input_operand = $signed(input_raw);
	assign low_limit = $signed(low_raw);
	assign high_limit = $signed(high_raw);

	// ----------------------------------------------------------
	// comparison
	// ----------------------------------------------------------

	// signed two's complement compares
	assign at_or_above_high = input_operand >= high_limit;
	assign at_or_below_low = input_operand <= low_limit;
	assign at_or_above_low = input_operand >= low_limit;
	assign at_or_below_high = input_operand <= high_limit;

	// equal limits fall in the normal order
	assign reversed = high_limit < low_limit;

	// zone of the input, on checked before off in the normal order, off before on when reversed
	always_comb
	begin
		zone_now = hcb_pkg::hcb_zone_hold;
		if (!reversed)
		begin
			if (at_or_above_high)
				zone_now = hcb_pkg::hcb_zone_on;
			else if (at_or_below_low)
				zone_now = hcb_pkg::hcb_zone_off;
		end
		else
		begin
			if (at_or_above_low)
				zone_now = hcb_pkg::hcb_zone_off;
			else if (at_or_below_high)
				zone_now = hcb_pkg::hcb_zone_on;
		end
	end

	// ----------------------------------------------------------
	// output state
	// ----------------------------------------------------------

	// never forced off while disabled,
	// so a held-on output survives disabled scans
	// next state, changes only on an enabled evaluation
	always_comb
	begin
		state_next = state_reg;
		if (enable)
		begin
			unique case (zone_now)
				hcb_pkg::hcb_zone_on: state_next = hcb_pkg::hcb_out_on;
				hcb_pkg::hcb_zone_off: state_next = hcb_pkg::hcb_out_off;
				default: state_next = state_reg;
			endcase
		end
	end

	// output state register, off after reset
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			state_reg <= hcb_pkg::hcb_out_off;
		else if (ce)
			state_reg <= state_next;
	end

	// pulses freeze with the rest of the state while ce is low
	// one-cycle pulses marking each change of the output
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			switched_on_reg <= 1'b0;
			switched_off_reg <= 1'b0;
		end
		else if (ce)
		begin
			switched_on_reg <= (state_reg == hcb_pkg::hcb_out_off) && (state_next == hcb_pkg::hcb_out_on);
			switched_off_reg <= (state_reg == hcb_pkg::hcb_out_on) && (state_next == hcb_pkg::hcb_out_off);
		end
	end

	// ----------------------------------------------------------
	// status
	// ----------------------------------------------------------

	// frozen between enabled scans, so other blocks see
	// the zone that produced the present output
	// zone and limit order of the last enabled evaluation
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			zone_reg <= hcb_pkg::hcb_zone_hold;
			reversed_reg <= 1'b0;
		end
		else if (ce && enable)
		begin
			zone_reg <= zone_now;
			reversed_reg <= reversed;
		end
	end

	// input operand as used by the evaluation, for other blocks
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			input_value_reg <= `HCB_VALUE_RESET;
		else if (ce && enable)
			input_value_reg <= input_raw;
	end

	// invalid operand index stores nothing but is reported
	// flagged configuration write (bad index, or unused source code, which is still stored), one cycle
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			cfg_error_reg <= 1'b0;
		else if (ce)
			cfg_error_reg <= bad_index || bad_input || bad_low || bad_high;
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------

	assign out_on = (state_reg == hcb_pkg::hcb_out_on);
	assign switched_on = switched_on_reg;
	assign switched_off = switched_off_reg;
	assign zone = zone_reg;
	assign limits_reversed = reversed_reg;
	assign cfg_error = cfg_error_reg;
	assign input_operand_value = input_value_reg;

endmodule
`default_nettype wire

// *** verification/hcb_hysteresis_compare_checker.sv ***
/*
 * assertions on the ports of the hysteresis compare block.
 * assumes one clock clk_sys and synchronous srst; bound to the top.
 */
`timescale 1ns/1ps
`default_nettype none

module hcb_hysteresis_compare_checker
(
	// clock, reset, clock enable
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	// block pin and output
	input wire logic enable,
	input wire logic out_on,
	input wire logic switched_on,
	input wire logic switched_off,
	// status
	input wire logic [1:0] zone,
	input wire logic [15:0] input_operand_value
);
	// all checks on the scan clock, quiet in reset except a_reset_clear
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	a_reset_clear: assert property (disable iff (1'b0) srst |=> !out_on && zone == 2'h0 && !switched_on)
		else $error("output not cleared by reset");
	a_hold_disabled: assert property (!(ce && enable) |=> $stable(out_on))
		else $error("output moved while disabled");
	a_status_frozen: assert property (!(ce && enable) |=> $stable(zone) && $stable(input_operand_value))
		else $error("operand or zone moved while disabled");
	a_rise_pulse: assert property ($past(ce) && !$past(srst) |-> switched_on == $rose(out_on))
		else $error("on pulse does not match output rise");
	a_fall_pulse: assert property ($past(ce) && !$past(srst) |-> switched_off == $fell(out_on))
		else $error("off pulse does not match output fall");
	a_zone_on_state: assert property (zone == 2'h1 |-> out_on)
		else $error("on zone with output off");
	a_zone_off_state: assert property (zone == 2'h2 |-> !out_on)
		else $error("off zone with output on");
	a_zone_hold_keep: assert property (ce && enable ##1 zone == 2'h0 |-> $stable(out_on))
		else $error("output switched between limits");
	a_on_cause: assert property (switched_on |-> zone == 2'h1)
		else $error("switched on outside on zone");

	// main scenarios seen
	c_on: cover property (switched_on);
	c_off: cover property (switched_off);
	c_hold_on: cover property (ce && enable ##1 zone == 2'h0 && out_on);
endmodule

bind hcb_hysteresis_compare hcb_hysteresis_compare_checker hcb_hysteresis_compare_checker_inst
(
	.clk_sys(clk_sys),
	.srst(srst),
	.ce(ce),
	.enable(enable),
	.out_on(out_on),
	.switched_on(switched_on),
	.switched_off(switched_off),
	.zone(zone),
	.input_operand_value(input_operand_value)
);

`default_nettype wire

// *** verification/hcb_source_model.sv ***
/*
 * model of the analog channels and other blocks feeding the operands.
 * assumes the bench loads one value per clk_sys edge.
 */
`timescale 1ns/1ps
`default_nettype none

module hcb_source_model
(
	// clock
	input wire logic clk_sys,
	// value load from the bench, 0..7 channels, 8..10 blocks
	input wire logic set_wr,
	input wire logic [3:0] set_idx,
	input wire logic [15:0] set_val,
	// live values
	output logic [7:0][15:0] analog_channel,
	output logic [15:0] bv_in,
	output logic [15:0] bv_lo,
	output logic [15:0] bv_hi
);
	logic [10:0][15:0] val_reg = '0;

	// a source changes on the clock edge, like a scanned block
	always_ff @(posedge clk_sys)
		if (set_wr)
			val_reg[set_idx] <= set_val;

	// fan out to channels and block values
	assign analog_channel = val_reg[7:0];
	assign bv_in = val_reg[8];
	assign bv_lo = val_reg[9];
	assign bv_hi = val_reg[10];
endmodule

`default_nettype wire

// *** verification/hcb_hysteresis_compare_tb_top.sv ***
/*
 * bench of the hysteresis compare block: corner table and random steps
 * against a reference of the switching decision.
 * assumes the source model stands in for channels and other blocks.
 */
`timescale 1ns/1ps
`default_nettype none

module hcb_hysteresis_compare_tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic enable = 1'b0;
	logic cfg_wr = 1'b0;
	logic [1:0] cfg_operand = 2'h0;
	logic [1:0] cfg_source = 2'h0;
	logic [15:0] cfg_constant = 16'h0000;
	logic [2:0] cfg_channel = 3'h0;
	logic set_wr = 1'b0;
	logic [3:0] set_idx = 4'h0;
	logic [15:0] set_val = 16'h0000;
	logic [7:0][15:0] analog_channel;
	logic [15:0] bv_in, bv_lo, bv_hi, input_operand_value;
	logic out_on, switched_on, switched_off, limits_reversed, cfg_error;
	logic [1:0] zone;
	logic [1:0] src_s [3] = '{2'h0, 2'h0, 2'h0};
	logic [15:0] con_s [3] = '{16'h0000, 16'h0000, 16'h0000};
	logic [2:0] chn_s [3] = '{3'h0, 3'h0, 3'h0};
	logic exp_on = 1'b0;
	logic exp_err = 1'b0;
	logic exp_rev = 1'b0;
	logic [1:0] exp_zone = 2'h0;
	logic [31:0] seed = 32'h0000_0033;
	int failures = 0;
	int tests_run = 0;
	// corner rows: input, low, high
	logic [15:0] tbl [11][3] = '{'{16'h0014, 16'h000a, 16'h0014}, '{16'h000f, 16'h000a, 16'h0014},
		'{16'h000a, 16'h000a, 16'h0014}, '{16'h000f, 16'h000a, 16'h0014}, '{16'h0014, 16'h0014, 16'h000a},
		'{16'h000a, 16'h0014, 16'h000a}, '{16'h000f, 16'h0014, 16'h000a}, '{16'h8000, 16'hfffb, 16'h7fff},
		'{16'h7fff, 16'h8000, 16'h7fff}, '{16'h0009, 16'h000a, 16'h000a}, '{16'h000a, 16'h000a, 16'h000a}};

	// 125 MHz scan clock
	always #4 clk_sys = ~clk_sys;

	hcb_hysteresis_compare hcb_hysteresis_compare_inst (.clk_sys(clk_sys), .srst(srst), .ce(ce),
		.enable(enable), .cfg_wr(cfg_wr), .cfg_operand(cfg_operand), .cfg_source(cfg_source),
		.cfg_constant(cfg_constant), .cfg_channel(cfg_channel), .analog_channel(analog_channel),
		.block_value_input(bv_in), .block_value_low(bv_lo), .block_value_high(bv_hi), .out_on(out_on),
		.switched_on(switched_on), .switched_off(switched_off), .zone(zone), .limits_reversed(limits_reversed),
		.cfg_error(cfg_error), .input_operand_value(input_operand_value));

	hcb_source_model hcb_source_model_inst (.clk_sys(clk_sys), .set_wr(set_wr), .set_idx(set_idx),
		.set_val(set_val), .analog_channel(analog_channel), .bv_in(bv_in), .bv_lo(bv_lo), .bv_hi(bv_hi));

	// xorshift step for repeatable random values
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// live value of one operand under the current configuration
	function automatic logic [15:0] opv(input int k);
		if (src_s[k] == 2'h0)
			return con_s[k];
		if (src_s[k] == 2'h1)
			return analog_channel[chn_s[k]];
		return (k == 0) ? bv_in : ((k == 1) ? bv_lo : bv_hi);
	endfunction

	// switching decision, signed, on tested first in the normal order, off first when reversed
	function automatic logic ref_on(input logic p, input logic signed [15:0] i, l, h);
		if (h >= l)
			return (i >= h) ? 1'b1 : ((i <= l) ? 1'b0 : p);
		return (i >= l) ? 1'b0 : ((i <= h) ? 1'b1 : p);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		tests_run++;
		if (got !== want)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask

	// one clock: predict from settled inputs, compare after the edge
	task automatic step();
		logic [15:0] iv;
		logic [15:0] lv;
		logic [15:0] hv;
		logic ev;
		iv = opv(0);
		lv = opv(1);
		hv = opv(2);
		ev = ce && enable;
		if (ev)
		begin
			exp_zone = ref_on(1'b0, iv, lv, hv) ? 2'h1 : (ref_on(1'b1, iv, lv, hv) ? 2'h0 : 2'h2);
			exp_rev = $signed(hv) < $signed(lv);
			exp_on = ref_on(exp_on, iv, lv, hv);
		end
		if (ce)
			exp_err = cfg_wr && (cfg_operand == 2'h3 || cfg_source == 2'h3);
		if (ce && cfg_wr && cfg_operand != 2'h3)
		begin
			src_s[cfg_operand] = cfg_source;
			con_s[cfg_operand] = cfg_constant;
			chn_s[cfg_operand] = cfg_channel;
		end
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(out_on, exp_on);
		chk(cfg_error, exp_err);
		chk(zone, exp_zone);
		chk(limits_reversed, exp_rev);
		if (ev)
			chk(input_operand_value, iv);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		srst = 1'b0;
		chk(out_on, 1'b0);
		enable = 1'b1;
		step();
		$display("test reset_defaults done");
		for (int r = 0; r < 11; r++)
		begin
			enable = 1'b0;
			cfg_wr = 1'b1;
			for (int k = 0; k < 3; k++)
			begin
				cfg_operand = k[1:0];
				cfg_constant = tbl[r][k];
				step();
			end
			cfg_wr = 1'b0;
			enable = 1'b1;
			step();
		end
		$display("test corner_table done");
		// reset in mid-run with the output on
		enable = 1'b0;
		srst = 1'b1;
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		src_s = '{2'h0, 2'h0, 2'h0};
		con_s = '{16'h0000, 16'h0000, 16'h0000};
		chn_s = '{3'h0, 3'h0, 3'h0};
		exp_on = 1'b0;
		exp_zone = 2'h0;
		exp_rev = 1'b0;
		chk(out_on, 1'b0);
		chk(input_operand_value, 16'h0000);
		step();
		$display("test reset_midrun done");
		for (int t = 0; t < 600; t++)
		begin
			seed = xs(seed);
			enable = seed[0];
			ce = seed[3:1] != 3'h0;
			cfg_wr = seed[6:4] == 3'h0;
			cfg_operand = seed[8:7];
			cfg_source = seed[10:9];
			cfg_channel = seed[13:11];
			cfg_constant = seed[31:16];
			set_wr = 1'b1;
			set_idx = seed[27:24] % 4'hb;
			seed = xs(seed);
			set_val = seed[15:0];
			step();
		end
		$display("test random_steps done");
		end_sim();
	end

	// watchdog, far beyond the few thousand ns the tests take
	initial
	begin
		#100000;
		failures++;
		end_sim();
	end
endmodule

`default_nettype wire
